// >>> dtm_pkg.sv
//------------------------------------------------------------
// Overview of operation
// [R1] Positive request off arms monitoring of motion toward increasing addresses.
// [R2] Negative request off arms monitoring of motion toward decreasing addresses.
// [R3] Direction checks start after their own separate per-direction delay.
// [R4] Active direction check compares speed against the shared stop-speed threshold.
// [R5] Direction check stops when its request returns on.
// [R6] Command speed over threshold trips after the speed detection delay.
// [R7] Feedback speed continuously over threshold for the delay trips.
// [R8] Travel window starts at once, measured from position latched then.
// [R9] Relative travel must stay within positive and negative permissible distances.
// [R10] Travel window ends when its request returns on.
// [R11] Travel violation trips after the position detection delay.
// [R12] Controller should use second safe stop to supervise standstill afterwards.
// [R13] Torque guard starts at once, checks both torque command and feedback.
// [R14] Torque guard ends when its request returns on.
// [R15] Four upper/lower limit pairs, each picked by its own request.
// [R16] Several active: smallest upper and largest lower limit apply.
// [R17] Torque command outside limits trips after torque detection delay.
// [R18] Torque feedback continuously outside limits for the delay trips.
// [R19] A shut-off request removes energy from the motor.
// [R20] Any one valid trigger activates the shut-off.
// [R21] Shut-off stays latched until alarm reset.
//------------------------------------------------------------
package dtm_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CONTROL     = 8'h00;
  localparam logic [7:0] OFS_STATUS      = 8'h04;
  localparam logic [7:0] OFS_STOP_SPEED  = 8'h08;
  localparam logic [7:0] OFS_SPEED_DLY   = 8'h0C;
  localparam logic [7:0] OFS_POS_DLY     = 8'h10;
  localparam logic [7:0] OFS_PDIR_DLY    = 8'h14;
  localparam logic [7:0] OFS_NDIR_DLY    = 8'h18;
  localparam logic [7:0] OFS_TRAV_POS    = 8'h1C;
  localparam logic [7:0] OFS_TRAV_NEG    = 8'h20;
  localparam logic [7:0] OFS_TORQUE_DLY  = 8'h24;
  localparam logic [7:0] OFS_UPPER_BASE  = 8'h28;
  localparam logic [7:0] OFS_LOWER_BASE  = 8'h38;
  localparam logic [7:0] OFS_LAST        = 8'h44;
  // control and status fields
  localparam int         BIT_ALARM_RESET = 0;
  localparam int         BIT_STO         = 0;
  localparam int         BIT_CAUSE_LO    = 1;
  localparam int         BIT_GUARD_LO    = 8;
  // reset values
  localparam logic [31:0] RST_ZERO       = 32'h0000_0000;
  localparam logic [31:0] RST_UPPER      = 32'h7FFF_FFFF;
  localparam logic [31:0] RST_LOWER      = 32'h8000_0000;
  // request input bit positions, all active low
  localparam int         REQ_PDIR        = 0;
  localparam int         REQ_NDIR        = 1;
  localparam int         REQ_TRAVEL      = 2;
  localparam int         REQ_TORQUE_LO   = 3;
  localparam int         REQ_W           = 7;
endpackage : dtm_pkg

// >>> dtm_safety_monitor.sv
`timescale 1ns/1ps
module dtm_safety_monitor #(
  parameter int DW = 32
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 positive_direction_request_n,
  input  wire logic                 negative_direction_request_n,
  input  wire logic                 travel_window_request_n,
  input  wire logic [3:0]           torque_limit_request_n,
  input  wire logic signed [DW-1:0] speed_cmd,
  input  wire logic signed [DW-1:0] speed_fb,
  input  wire logic signed [DW-1:0] position_fb,
  input  wire logic signed [DW-1:0] torque_cmd,
  input  wire logic signed [DW-1:0] torque_fb,
  output logic                      safe_torque_off,
  output logic                      motor_energy_enable
);

  //----------------------------------------------------------
  // helpers
  //----------------------------------------------------------
  // saturating up-counter so a long hold never wraps into a false pass
  function automatic logic [31:0] tick(input logic [31:0] c, input logic run);
    if (!run) return 32'h0000_0000;
    return (c == 32'hFFFF_FFFF) ? c : c + 32'h0000_0001;
  endfunction : tick

  function automatic logic outside(input logic signed [DW-1:0] v,
                                   input logic signed [DW-1:0] hi,
                                   input logic signed [DW-1:0] lo);
    return (v > hi) || (v < lo);
  endfunction : outside

  //----------------------------------------------------------
  // request pin synchronisers
  //----------------------------------------------------------
  logic [dtm_pkg::REQ_W-1:0] s1_r, s2_r, s3_r, req_n_r, req_n_nxt;
  logic [dtm_pkg::REQ_W-1:0] pins;

  assign pins = {torque_limit_request_n, travel_window_request_n,
                 negative_direction_request_n, positive_direction_request_n};

  // a bit changes only once second and third stage agree
  always_comb begin
    req_n_nxt = req_n_r;
    for (int i = 0; i < dtm_pkg::REQ_W; i++) begin
      if (s2_r[i] == s3_r[i]) req_n_nxt[i] = s3_r[i];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r    <= '1;
      s2_r    <= '1;
      s3_r    <= '1;
      req_n_r <= '1;
    end else begin
      s1_r    <= pins;
      s2_r    <= s1_r;
      s3_r    <= s2_r;
      req_n_r <= req_n_nxt;
    end
  end

  //----------------------------------------------------------
  // configuration registers and apb slave
  //----------------------------------------------------------
  logic [31:0] stop_speed_r, speed_dly_r, pos_dly_r, pdir_dly_r, ndir_dly_r;
  logic [31:0] trav_pos_r, trav_neg_r, torque_dly_r;
  logic [31:0] upper_r [4];
  logic [31:0] lower_r [4];
  logic [31:0] stop_speed_nxt, speed_dly_nxt, pos_dly_nxt, pdir_dly_nxt, ndir_dly_nxt;
  logic [31:0] trav_pos_nxt, trav_neg_nxt, torque_dly_nxt;
  logic [31:0] upper_nxt [4];
  logic [31:0] lower_nxt [4];
  logic [31:0] prdata_r, prdata_nxt;
  logic        pready_r, pslverr_r, pslverr_nxt, wr_go, alarm_reset;
  logic [31:0] status_w;
  logic        sto_r;
  logic [4:0]  cause_r;
  logic [2:0]  guards;

  assign wr_go       = psel && penable && pready_r && pwrite;
  assign alarm_reset = wr_go && (paddr == dtm_pkg::OFS_CONTROL)
                       && pwdata[dtm_pkg::BIT_ALARM_RESET];
  assign status_w    = {21'h00_0000, guards, 2'h0, cause_r, sto_r};

  // read mux and decode in the setup cycle, answer in the first access cycle
  always_comb begin
    prdata_nxt  = 32'h0000_0000;
    pslverr_nxt = 1'b0;
    if (paddr[1:0] != 2'b00 || paddr > dtm_pkg::OFS_LAST) pslverr_nxt = 1'b1;
    else begin
      unique case (paddr)
        dtm_pkg::OFS_CONTROL:    prdata_nxt = 32'h0000_0000;
        dtm_pkg::OFS_STATUS:     prdata_nxt = status_w;
        dtm_pkg::OFS_STOP_SPEED: prdata_nxt = stop_speed_r;
        dtm_pkg::OFS_SPEED_DLY:  prdata_nxt = speed_dly_r;
        dtm_pkg::OFS_POS_DLY:    prdata_nxt = pos_dly_r;
        dtm_pkg::OFS_PDIR_DLY:   prdata_nxt = pdir_dly_r;
        dtm_pkg::OFS_NDIR_DLY:   prdata_nxt = ndir_dly_r;
        dtm_pkg::OFS_TRAV_POS:   prdata_nxt = trav_pos_r;
        dtm_pkg::OFS_TRAV_NEG:   prdata_nxt = trav_neg_r;
        dtm_pkg::OFS_TORQUE_DLY: prdata_nxt = torque_dly_r;
        default: begin
          if (paddr < dtm_pkg::OFS_LOWER_BASE)
            prdata_nxt = upper_r[2'((paddr - dtm_pkg::OFS_UPPER_BASE) >> 2)];
          else
            prdata_nxt = lower_r[2'((paddr - dtm_pkg::OFS_LOWER_BASE) >> 2)];
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= dtm_pkg::RST_ZERO;
    end else begin
      pready_r  <= psel && !penable;
      pslverr_r <= psel && !penable && pslverr_nxt;
      prdata_r  <= (psel && !penable && !pwrite) ? prdata_nxt : dtm_pkg::RST_ZERO;
    end
  end

  // next configuration: only a clean write on its completing edge changes it,
  // so a refused address can never corrupt a threshold
  always_comb begin
    stop_speed_nxt = stop_speed_r;
    speed_dly_nxt  = speed_dly_r;
    pos_dly_nxt    = pos_dly_r;
    pdir_dly_nxt   = pdir_dly_r;
    ndir_dly_nxt   = ndir_dly_r;
    trav_pos_nxt   = trav_pos_r;
    trav_neg_nxt   = trav_neg_r;
    torque_dly_nxt = torque_dly_r;
    upper_nxt      = upper_r;
    lower_nxt      = lower_r;
    if (wr_go && !pslverr_r) begin
      unique case (paddr)
        dtm_pkg::OFS_STOP_SPEED: stop_speed_nxt = pwdata;
        dtm_pkg::OFS_SPEED_DLY:  speed_dly_nxt  = pwdata;
        dtm_pkg::OFS_POS_DLY:    pos_dly_nxt    = pwdata;
        dtm_pkg::OFS_PDIR_DLY:   pdir_dly_nxt   = pwdata;
        dtm_pkg::OFS_NDIR_DLY:   ndir_dly_nxt   = pwdata;
        dtm_pkg::OFS_TRAV_POS:   trav_pos_nxt   = pwdata;
        dtm_pkg::OFS_TRAV_NEG:   trav_neg_nxt   = pwdata;
        dtm_pkg::OFS_TORQUE_DLY: torque_dly_nxt = pwdata;
        default: begin
          if (paddr >= dtm_pkg::OFS_LOWER_BASE)
            lower_nxt[2'((paddr - dtm_pkg::OFS_LOWER_BASE) >> 2)] = pwdata;
          else if (paddr >= dtm_pkg::OFS_UPPER_BASE)
            upper_nxt[2'((paddr - dtm_pkg::OFS_UPPER_BASE) >> 2)] = pwdata;
        end
      endcase
    end
  end

  // configuration registers only; limits open wide after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_speed_r <= dtm_pkg::RST_ZERO;
      speed_dly_r  <= dtm_pkg::RST_ZERO;
      pos_dly_r    <= dtm_pkg::RST_ZERO;
      pdir_dly_r   <= dtm_pkg::RST_ZERO;
      ndir_dly_r   <= dtm_pkg::RST_ZERO;
      trav_pos_r   <= dtm_pkg::RST_ZERO;
      trav_neg_r   <= dtm_pkg::RST_ZERO;
      torque_dly_r <= dtm_pkg::RST_ZERO;
      for (int i = 0; i < 4; i++) begin
        upper_r[i] <= dtm_pkg::RST_UPPER;
        lower_r[i] <= dtm_pkg::RST_LOWER;
      end
    end else begin
      stop_speed_r <= stop_speed_nxt;
      speed_dly_r  <= speed_dly_nxt;
      pos_dly_r    <= pos_dly_nxt;
      pdir_dly_r   <= pdir_dly_nxt;
      ndir_dly_r   <= ndir_dly_nxt;
      trav_pos_r   <= trav_pos_nxt;
      trav_neg_r   <= trav_neg_nxt;
      torque_dly_r <= torque_dly_nxt;
      upper_r      <= upper_nxt;
      lower_r      <= lower_nxt;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;

  //----------------------------------------------------------
  // monitors
  //----------------------------------------------------------
  logic              pdir_on, ndir_on, trav_on, torq_on;
  logic [31:0]       parm_r, narm_r, scmd_r, sfb_r, trav_r, tcmd_r, tfb_r;
  logic [31:0]       parm_nxt, narm_nxt, scmd_nxt, sfb_nxt, trav_nxt, tcmd_nxt, tfb_nxt;
  logic              trav_on_r, scmd_p_r, trav_p_r, tcmd_p_r;
  logic              scmd_p_nxt, trav_p_nxt, tcmd_p_nxt, sto_nxt;
  logic signed [DW-1:0] origin_r, origin_nxt, rel, hi_lim, lo_lim, sth;
  logic              pchk, nchk, cmd_bad, fb_bad, trav_bad, tc_bad, tf_bad;
  logic [4:0]        trip, cause_nxt;
  logic              energy_r, energy_nxt;

  assign pdir_on = !req_n_r[dtm_pkg::REQ_PDIR];                         // [R1]
  assign ndir_on = !req_n_r[dtm_pkg::REQ_NDIR];                         // [R2]
  assign trav_on = !req_n_r[dtm_pkg::REQ_TRAVEL];
  assign torq_on = !(&req_n_r[dtm_pkg::REQ_TORQUE_LO +: 4]);            // [R13] [R14]
  assign guards  = {torq_on, trav_on, pdir_on || ndir_on};
  assign sth     = DW'(stop_speed_r);

  // active limit pair: tightest of all requested pairs
  always_comb begin
    hi_lim = DW'(dtm_pkg::RST_UPPER);
    lo_lim = DW'(dtm_pkg::RST_LOWER);
    for (int i = 0; i < 4; i++) begin
      if (!req_n_r[dtm_pkg::REQ_TORQUE_LO + i]) begin                   // [R15]
        // limits are signed: an unsigned compare would misorder a positive lower limit
        if ($signed(DW'(upper_r[i])) < hi_lim) hi_lim = DW'(upper_r[i]); // [R16]
        if ($signed(DW'(lower_r[i])) > lo_lim) lo_lim = DW'(lower_r[i]); // [R16]
      end
    end
  end

  // violation detection and detection-delay timers
  always_comb begin
    // direction checks live only after each own arm delay
    parm_nxt = tick(parm_r, pdir_on);                                   // [R3] [R5]
    narm_nxt = tick(narm_r, ndir_on);                                   // [R3] [R5]
    pchk     = pdir_on && (parm_r >= pdir_dly_r);                       // [R3]
    nchk     = ndir_on && (narm_r >= ndir_dly_r);                       // [R3]
    cmd_bad  = (pchk && speed_cmd > sth) || (nchk && speed_cmd < -sth); // [R4]
    fb_bad   = (pchk && speed_fb > sth) || (nchk && speed_fb < -sth);   // [R4]
    // command excess latches a pending trip; feedback must persist
    scmd_p_nxt = (pchk || nchk) && (scmd_p_r || cmd_bad);               // [R6]
    scmd_nxt   = tick(scmd_r, scmd_p_nxt);
    sfb_nxt    = tick(sfb_r, fb_bad);                                   // [R7]
    // origin caught on the cycle the window opens
    origin_nxt = (trav_on && !trav_on_r) ? position_fb : origin_r;      // [R8]
    rel        = position_fb - origin_r;
    trav_bad   = trav_on_r && trav_on
                 && (rel > $signed(DW'(trav_pos_r)) || rel < $signed(DW'(trav_neg_r))); // [R9]
    trav_p_nxt = trav_on && (trav_p_r || trav_bad);                     // [R10] [R11]
    trav_nxt   = tick(trav_r, trav_p_nxt);
    tc_bad     = torq_on && outside(torque_cmd, hi_lim, lo_lim);        // [R13]
    tf_bad     = torq_on && outside(torque_fb, hi_lim, lo_lim);         // [R13]
    tcmd_p_nxt = torq_on && (tcmd_p_r || tc_bad);                       // [R14] [R17]
    tcmd_nxt   = tick(tcmd_r, tcmd_p_nxt);
    tfb_nxt    = tick(tfb_r, tf_bad);                                   // [R18]
    trip[0]    = scmd_p_r && (scmd_r >= speed_dly_r);                   // [R6]
    trip[1]    = fb_bad && (sfb_r >= speed_dly_r);                      // [R7]
    trip[2]    = trav_p_r && (trav_r >= pos_dly_r);                     // [R11]
    trip[3]    = tcmd_p_r && (tcmd_r >= torque_dly_r);                  // [R17]
    trip[4]    = tf_bad && (tfb_r >= torque_dly_r);                     // [R18]
    // a trip in the reset cycle wins over the reset
    cause_nxt  = (alarm_reset ? 5'h00 : cause_r) | trip;                // [R21]
    sto_nxt    = (sto_r && !alarm_reset) || (|trip);                    // [R20] [R21]
    energy_nxt = !sto_nxt;                                              // [R19]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      parm_r    <= dtm_pkg::RST_ZERO;
      narm_r    <= dtm_pkg::RST_ZERO;
      scmd_r    <= dtm_pkg::RST_ZERO;
      sfb_r     <= dtm_pkg::RST_ZERO;
      trav_r    <= dtm_pkg::RST_ZERO;
      tcmd_r    <= dtm_pkg::RST_ZERO;
      tfb_r     <= dtm_pkg::RST_ZERO;
      scmd_p_r  <= 1'b0;
      trav_p_r  <= 1'b0;
      tcmd_p_r  <= 1'b0;
      trav_on_r <= 1'b0;
      origin_r  <= '0;
      cause_r   <= 5'h00;
      sto_r     <= 1'b0;
      energy_r  <= 1'b1;
    end else begin
      parm_r    <= parm_nxt;
      narm_r    <= narm_nxt;
      scmd_r    <= scmd_nxt;
      sfb_r     <= sfb_nxt;
      trav_r    <= trav_nxt;
      tcmd_r    <= tcmd_nxt;
      tfb_r     <= tfb_nxt;
      scmd_p_r  <= scmd_p_nxt;
      trav_p_r  <= trav_p_nxt;
      tcmd_p_r  <= tcmd_p_nxt;
      trav_on_r <= trav_on;
      origin_r  <= origin_nxt;
      cause_r   <= cause_nxt;
      sto_r     <= sto_nxt;
      energy_r  <= energy_nxt;
    end
  end

  // shut-off and energy enable each from their own flop, no gate on the pin
  assign safe_torque_off     = sto_r;                                   // [R19]
  assign motor_energy_enable = energy_r;                                // [R19]

endmodule : dtm_safety_monitor

// >>> dtm_ctrl_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// safety controller: active-low monitoring request levels
// ------------------------------------------------------------
module dtm_ctrl_model (
  input  wire logic                        pclk,
  output logic [dtm_pkg::REQ_W-1:0]        req_n
);
  // all requests start on (high), so nothing is monitored until asked
  initial req_n = 7'h7F;

  // levels change just after an edge and are held until the next call;
  // standstill after a travel move is left to the caller's sequence
  task set_req(input logic [dtm_pkg::REQ_W-1:0] r);
    @(posedge pclk);
    req_n <= r;
  endtask : set_req
endmodule : dtm_ctrl_model

// >>> dtm_check_monitor.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// port checker for the safety monitor
// ------------------------------------------------------------
module dtm_check_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        positive_direction_request_n,
  input wire logic        negative_direction_request_n,
  input wire logic        travel_window_request_n,
  input wire logic [3:0]  torque_limit_request_n,
  input wire logic        safe_torque_off,
  input wire logic        motor_energy_enable
);
  logic [4:0] idle_r;
  logic [4:0] idle_nxt;
  logic       quiet;
  logic       clr;
  // alarm reset write as it completes on the bus
  assign clr   = psel && penable && pready && pwrite && paddr == dtm_pkg::OFS_CONTROL && pwdata[0];
  assign quiet = positive_direction_request_n && negative_direction_request_n && travel_window_request_n
                 && (&torque_limit_request_n);
  // cycles with every request on; saturates so it never wraps back
  always_comb begin
    idle_nxt = idle_r;
    if (!quiet) idle_nxt = 5'h00;
    else if (idle_r != 5'h1F) idle_nxt = idle_r + 5'h01;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) idle_r <= 5'h00;
    else idle_r <= idle_nxt;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_energy_inverse: assert property (motor_energy_enable == !safe_torque_off)
    else $error("energy enable not inverse of shut-off");
  a_sto_stays_latched: assert property (safe_torque_off && !clr |=> safe_torque_off)
    else $error("shut-off dropped without alarm reset");
  a_quiet_no_trip: assert property (idle_r > 5'h0C |-> !$rose(safe_torque_off))
    else $error("shut-off rose with no guard active");
  a_clear_releases: assert property (clr && idle_r > 5'h0C |=> !safe_torque_off ##1 !safe_torque_off)
    else $error("alarm reset did not release shut-off");
  a_ready_after_setup: assert property (psel && !penable |=> pready && penable)
    else $error("no ready in first access cycle");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  a_err_bad_addr: assert property (psel && !penable && (paddr[1:0] != 2'h0 || paddr > dtm_pkg::OFS_LAST) |=> pslverr)
    else $error("bad address not refused");
endmodule : dtm_check_monitor

bind dtm_safety_monitor dtm_check_monitor u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .positive_direction_request_n(positive_direction_request_n),
  .negative_direction_request_n(negative_direction_request_n),
  .travel_window_request_n(travel_window_request_n), .torque_limit_request_n(torque_limit_request_n),
  .safe_torque_off(safe_torque_off), .motor_energy_enable(motor_energy_enable)
);

// >>> direction_travel_torque_safety_monitor_test.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// self-checking bench: probes each guard through request pins
// ------------------------------------------------------------
module direction_travel_torque_safety_monitor_test;
  logic               pclk;
  logic               presetn;
  logic               psel;
  logic               penable;
  logic               pwrite;
  logic [7:0]         paddr;
  logic [31:0]        pwdata;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  logic [6:0]         req_n;
  logic signed [31:0] speed_cmd;
  logic signed [31:0] speed_fb;
  logic signed [31:0] position_fb;
  logic signed [31:0] torque_cmd;
  logic signed [31:0] torque_fb;
  logic               safe_torque_off;
  logic               motor_energy_enable;
  logic [31:0]        q;
  logic               e;
  int                 miscompares;
  int                 total_checks;
  // 08..44: threshold, delays, travel limits, torque pairs
  int cfg [16] = '{100, 10, 4, 30, 0, 50, -30, 2, 300, 100, 250, 400, -50, -200, -250, -10};

  dtm_safety_monitor uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .positive_direction_request_n(req_n[0]), .negative_direction_request_n(req_n[1]),
    .travel_window_request_n(req_n[2]), .torque_limit_request_n(req_n[6:3]), .speed_cmd(speed_cmd),
    .speed_fb(speed_fb), .position_fb(position_fb), .torque_cmd(torque_cmd), .torque_fb(torque_fb),
    .safe_torque_off(safe_torque_off), .motor_energy_enable(motor_energy_enable));
  dtm_ctrl_model u_ctl (.pclk(pclk), .req_n(req_n));

  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // one transfer plus an idle edge, so back-to-back calls never clash
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task settle(input int n, input logic exp);
    repeat (n) @(posedge pclk);
    chk({31'h0, safe_torque_off}, {31'h0, exp});
  endtask : settle

  task trip(input int n);
    for (int i = 0; i < n && safe_torque_off !== 1'b1; i++) @(posedge pclk);
    chk({31'h0, safe_torque_off}, 32'h1);
  endtask : trip

  // all requests back on, then latch check and alarm reset
  task rearm(input logic exp);
    u_ctl.set_req(7'h7F);
    speed_cmd <= 0;
    speed_fb <= 0;
    position_fb <= 1000;
    torque_cmd <= 0;
    torque_fb <= 0;
    settle(12, exp);
    apb(1'b1, 8'h00, 32'h1);
    settle(2, 1'b0);
    chk({31'h0, motor_energy_enable}, 32'h1);
  endtask : rearm

  // drop requests r, optionally end them, then drive input s to v
  task probe(input logic [6:0] r, input int s, input int v, input int hold, input logic endf, input logic exp);
    u_ctl.set_req(r);
    settle(8, 1'b0);
    if (endf) begin
      u_ctl.set_req(7'h7F);
      settle(8, 1'b0);
    end
    case (s)
      0: speed_cmd <= v;
      1: speed_fb <= v;
      2: position_fb <= v;
      3: torque_cmd <= v;
      default: torque_fb <= v;
    endcase
    settle(hold, 1'b0);
    if (exp) trip(60);
    else settle(60, 1'b0);
    rearm(exp);
  endtask : probe

  task report_and_stop;
    $display("checks %0d errors %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop

  // 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // watchdog: the sequence needs well under 5000 cycles
  initial begin
    #200000;
    miscompares++;
    report_and_stop;
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {speed_cmd, speed_fb, torque_cmd, torque_fb} = '0;
    position_fb = 1000;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h28, 32'h0);
    chk(q, dtm_pkg::RST_UPPER);
    apb(1'b0, 8'h44, 32'h0);
    chk(q, dtm_pkg::RST_LOWER);
    apb(1'b0, 8'h48, 32'h0);
    chk({31'h0, e}, 32'h1);
    for (int i = 0; i < 16; i++) apb(1'b1, 8'h08 + 8'(4 * i), cfg[i]);
    for (int i = 0; i < 16; i++) begin
      apb(1'b0, 8'h08 + 8'(4 * i), 32'h0);
      chk(q, cfg[i]);
    end
    probe(7'h7E, 0, 150, 15, 1'b0, 1'b1);
    apb(1'b1, 8'h14, 32'h0);
    probe(7'h7E, 0, -500, 0, 1'b0, 1'b0);
    probe(7'h7D, 1, 500, 0, 1'b0, 1'b0);
    probe(7'h7D, 1, -100, 0, 1'b0, 1'b0);
    probe(7'h7D, 1, -101, 0, 1'b0, 1'b1);
    probe(7'h7E, 0, 150, 0, 1'b1, 1'b0);
    // feedback bursts shorter than the delay must not trip
    u_ctl.set_req(7'h7E);
    settle(8, 1'b0);
    repeat (4) begin
      speed_fb <= 150;
      repeat (5) @(posedge pclk);
      speed_fb <= 0;
      repeat (5) @(posedge pclk);
    end
    rearm(1'b0);
    probe(7'h7E, 1, 150, 0, 1'b0, 1'b1);
    probe(7'h7B, 2, 1050, 0, 1'b0, 1'b0);
    probe(7'h7B, 2, 970, 0, 1'b0, 1'b0);
    probe(7'h7B, 2, 969, 0, 1'b0, 1'b1);
    probe(7'h7B, 2, 1051, 0, 1'b0, 1'b1);
    probe(7'h7B, 2, 5000, 0, 1'b1, 1'b0);
    probe(7'h77, 3, 300, 0, 1'b0, 1'b0);
    probe(7'h77, 3, 301, 0, 1'b0, 1'b1);
    probe(7'h6F, 4, 101, 0, 1'b0, 1'b1);
    probe(7'h6F, 4, -200, 0, 1'b0, 1'b0);
    probe(7'h5F, 3, -251, 0, 1'b0, 1'b1);
    probe(7'h3F, 4, -11, 0, 1'b0, 1'b1);
    probe(7'h67, 3, 150, 0, 1'b0, 1'b1);
    probe(7'h67, 3, -60, 0, 1'b0, 1'b1);
    probe(7'h3E, 3, 401, 0, 1'b0, 1'b1);
    probe(7'h77, 3, 999, 0, 1'b1, 1'b0);
    // status shows latch, torque feedback cause and live torque guard, then clears
    u_ctl.set_req(7'h77);
    settle(8, 1'b0);
    torque_fb <= 400;
    trip(60);
    apb(1'b0, 8'h04, 32'h0);
    chk(q, 32'h0000_0421);
    rearm(1'b1);
    apb(1'b0, 8'h04, 32'h0);
    chk(q, 32'h0000_0000);
    report_and_stop;
  end
endmodule : direction_travel_torque_safety_monitor_test
